// [cell_monitor_self_test_seq.sv]
`timescale 1ns/1ps

module cell_monitor_self_test_seq #(
  parameter int unsigned CHANNELS = self_test_pkg::MAX_CHANNELS
) (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                cycle_start,          // Sequencer starts a cycle
  input  wire logic                cycle_done,           // Sequencer finishes a cycle
  input  wire logic                chan_strobe,          // One channel was converted
  input  wire logic [3:0]          chan_index,           // Channel just converted
  input  wire logic [CHANNELS-1:0] chan_requested,       // Channels wanted this cycle
  input  wire logic                cell_fault,           // Any OV/UV/temperature fault
  input  wire logic                chain_match,          // Chain input tracks enable clock
  input  wire logic                enable_clock_in,
  input  wire logic                enabled,              // Valid enable clock present
  input  wire logic                step_strobe,          // Analog result ready for step
  input  wire logic                cmp_above_lower,      // Comparator: input above lower
  input  wire logic                cmp_below_upper,      // Comparator: input below upper
  input  wire logic [11:0]         ref_code,             // Main reference digitised
  input  wire logic [11:0]         adc_code,             // Decimation filter output
  input  wire logic [CHANNELS-1:0] open_wire_ov,         // OV seen under test pull-down
  input  wire logic                duty_cycle_select_raw,
  input  wire logic                duty_cycle_select_float,
  input  wire logic                self_test_request_n_in,
  output logic                     self_test_request_n_out,
  output logic                     self_test_request_n_oe,
  output logic                     self_test_pass,
  output logic                     self_test_active,     // Cycle being run is a self test
  output logic                     uv_check_enable,      // Undervoltage comparison allowed
  output logic [1:0]               threshold_mode,       // 0 window, 1 upper low, 2 lower high
  output logic                     zebra_select,         // Which test waveform is applied
  output logic                     duty_cycle_select,
  output logic                     status_clock_out,
  output logic                     status_clock_out_n
);

  // Elaboration check: channel index is four bits wide
  if (CHANNELS < 2 || CHANNELS > 16) begin : g_chk
    $error("CHANNELS must be between 2 and 16");
  end

  // Reset release through two flops
  logic rst_meta_r;
  logic rst_n;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // Request line synchroniser and falling edge detector
  logic req_meta_r;  // First stage, read only by second
  logic req_sync_r;
  logic req_prev_r;
  logic req_fall;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_meta_r <= 1'b1;
      req_sync_r <= 1'b1;
      req_prev_r <= 1'b1;
    end else begin
      req_meta_r <= self_test_request_n_in;
      req_sync_r <= req_meta_r;
      req_prev_r <= req_sync_r;
    end
  end
  // Our own pull-down also appears on the line, so edges during a test are ours
  assign req_fall = req_prev_r & ~req_sync_r & ~self_test_active;

  // Quiet-cycle counter for the automatic test
  logic [self_test_pkg::AUTO_CNT_W-1:0] quiet_cnt_r;
  logic                                 auto_due;
  assign auto_due = (quiet_cnt_r == (self_test_pkg::AUTO_CNT_W)'(self_test_pkg::AUTO_TEST_CYCLES - 1));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      quiet_cnt_r <= '0;
    end else if (req_fall || (cycle_done && self_test_active)) begin
      quiet_cnt_r <= '0; // Any outside request or finished test restarts the count
    end else if (cycle_done && !auto_due) begin
      quiet_cnt_r <= quiet_cnt_r + 1'b1;
    end
  end

  // Pending request: many edges merge into one test
  logic pending_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_r <= 1'b0;
    end else if (req_fall || (cycle_done && auto_due && !self_test_active)) begin
      pending_r <= 1'b1;
    end else if (cycle_start && !self_test_active) begin
      pending_r <= 1'b0; // Consumed as the next cycle turns into a self test
    end
  end

  // Self test cycle flag: the whole next cycle is given to the test, so a fresh
  // cell fault is reported one cycle later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      self_test_active <= 1'b0;
    end else if (cycle_start && pending_r && !self_test_active) begin
      self_test_active <= 1'b1;
    end else if (cycle_done) begin
      self_test_active <= 1'b0;
    end
  end

  // Open-collector line pulled low while testing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      self_test_request_n_out <= 1'b1;
      self_test_request_n_oe  <= 1'b0;
    end else begin
      self_test_request_n_out <= 1'b0;
      self_test_request_n_oe  <= (cycle_start && pending_r) || (self_test_active && !cycle_done);
    end
  end

  // Undervoltage check is skipped during tests to avoid pull-down false failures
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      uv_check_enable <= 1'b1;
    end else begin
      uv_check_enable <= !((cycle_start && pending_r) || (self_test_active && !cycle_done));
    end
  end

  // Channel coverage: mark each converted channel, compare at cycle end
  logic [CHANNELS-1:0] seen_r;
  logic                skip_err_r; // A cycle, self test or not, skipped a channel
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_r <= '0;
    end else if (cycle_start) begin
      seen_r <= '0;
    end else if (chan_strobe && (int'(chan_index) < CHANNELS)) begin
      seen_r[chan_index] <= 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      skip_err_r <= 1'b0;
    end else if (cycle_done && ((chan_requested & ~seen_r) != '0)) begin
      skip_err_r <= 1'b1; // set wins over the clear below
    end else if (cycle_done && self_test_active) begin
      skip_err_r <= 1'b0;
    end
  end

  // Reference tolerance check: band of nominal plus/minus the percentage
  function automatic logic ref_out_of_band(input logic [11:0] code);
    logic [15:0] dev;
    dev = (code > self_test_pkg::REF_NOMINAL_CODE) ?
          16'(code - self_test_pkg::REF_NOMINAL_CODE) :
          16'(self_test_pkg::REF_NOMINAL_CODE - code);
    return (32'(dev) * 32'd100) >
           (32'(self_test_pkg::REF_NOMINAL_CODE) * 32'(self_test_pkg::REF_TOL_PCT));
  endfunction : ref_out_of_band

  // Open wire on the checked lower inputs shows as overvoltage under the test sink
  logic [CHANNELS-1:0] open_mask;
  for (genvar g = 0; g < CHANNELS; g++) begin : g_open
    assign open_mask[g] = (g >= self_test_pkg::OPEN_CHECK_LO) &&
                          (g <= self_test_pkg::OPEN_CHECK_HI);
  end

  // Self test step sequencer
  self_test_pkg::step_e step_r;
  logic                 fail_r;   // Failure accumulated in this test
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step_r <= self_test_pkg::ST_IDLE;
    end else begin
      case (step_r)
        self_test_pkg::ST_IDLE:    if (cycle_start && pending_r && !self_test_active)
                                     step_r <= self_test_pkg::ST_CMP_WIN;
        self_test_pkg::ST_CMP_WIN: if (step_strobe) step_r <= self_test_pkg::ST_CMP_UP;
        self_test_pkg::ST_CMP_UP:  if (step_strobe) step_r <= self_test_pkg::ST_CMP_LO;
        self_test_pkg::ST_CMP_LO:  if (step_strobe) step_r <= self_test_pkg::ST_ZEBRA_A;
        self_test_pkg::ST_ZEBRA_A: if (step_strobe) step_r <= self_test_pkg::ST_ZEBRA_B;
        self_test_pkg::ST_ZEBRA_B: if (step_strobe) step_r <= self_test_pkg::ST_DONE;
        self_test_pkg::ST_DONE:    if (cycle_done) step_r <= self_test_pkg::ST_IDLE;
        default:                   step_r <= self_test_pkg::ST_IDLE;
      endcase
      if (cycle_done && step_r != self_test_pkg::ST_DONE) begin
        step_r <= self_test_pkg::ST_IDLE; // Cycle ended early: abandoned test
      end
    end
  end

  // Check each step result and collect failures
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fail_r <= 1'b0;
    end else if (step_r == self_test_pkg::ST_IDLE) begin
      fail_r <= 1'b0;
    end else if (step_strobe) begin
      case (step_r)
        // Inside the narrow window both comparators agree; reference checked too
        self_test_pkg::ST_CMP_WIN: if (!(cmp_above_lower && cmp_below_upper) ||
                                       ref_out_of_band(ref_code)) fail_r <= 1'b1;
        self_test_pkg::ST_CMP_UP:  if (cmp_below_upper) fail_r <= 1'b1;
        self_test_pkg::ST_CMP_LO:  if (cmp_above_lower) fail_r <= 1'b1;
        self_test_pkg::ST_ZEBRA_A: if (adc_code != self_test_pkg::ZEBRA_CODE) fail_r <= 1'b1;
        self_test_pkg::ST_ZEBRA_B: if (adc_code != ~self_test_pkg::ZEBRA_CODE) fail_r <= 1'b1;
        default:                   fail_r <= fail_r;
      endcase
    end else if ((open_wire_ov & open_mask) != '0 && step_r != self_test_pkg::ST_DONE) begin
      fail_r <= 1'b1;
    end
  end

  // Step outputs steering the analog path
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      threshold_mode <= 2'h0;
      zebra_select   <= 1'b0;
    end else begin
      threshold_mode <= (step_r == self_test_pkg::ST_CMP_UP) ? 2'h1 :
                        (step_r == self_test_pkg::ST_CMP_LO) ? 2'h2 : 2'h0;
      zebra_select   <= (step_r == self_test_pkg::ST_ZEBRA_B);
    end
  end

  // Pass output: updated only when a test completes, failure never halts monitoring
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      self_test_pass <= self_test_pkg::PASS_RESET;
    end else if (cycle_done && step_r == self_test_pkg::ST_DONE) begin
      self_test_pass <= !(fail_r || skip_err_r);
    end
  end

  // Floating configuration input falls to the shortest duty cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      duty_cycle_select <= 1'b1;
    end else begin
      duty_cycle_select <= duty_cycle_select_float | duty_cycle_select_raw;
    end
  end

  // Status clock is independent of test result; chain break stops it
  status_clock_gate u_gate (
    .clk                (clk),
    .rst_n              (rst_n),
    .cycle_done         (cycle_done),
    .all_ok             (enabled && chain_match && !cell_fault),
    .enable_clock_in    (enable_clock_in),
    .status_clock_out   (status_clock_out),
    .status_clock_out_n (status_clock_out_n)
  );

  // Assertions
  sequence s_test_end;
    cycle_done && step_r == self_test_pkg::ST_DONE;
  endsequence
  pass_after_test_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_test_end ##0 fail_r |=> !self_test_pass)
    else $error("pass not low after failed test");
  pass_recover_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_test_end ##0 (!fail_r && !skip_err_r) |=> self_test_pass)
    else $error("pass not restored after passing test");
  pass_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(cycle_done && step_r == self_test_pkg::ST_DONE) |=> $stable(self_test_pass))
    else $error("pass changed outside test end");
  line_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    self_test_active && !cycle_done |=> self_test_request_n_oe && !self_test_request_n_out)
    else $error("request line not pulled during test");
  uv_skip_a: assert property (@(posedge clk) disable iff (!rst_n)
    self_test_active && !cycle_done |=> !uv_check_enable)
    else $error("undervoltage check active in self test");
  edge_pending_a: assert property (@(posedge clk) disable iff (!rst_n)
    req_fall |=> pending_r)
    else $error("falling request not recorded");
  auto_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    cycle_done && auto_due && !self_test_active && !req_fall |=> pending_r && quiet_cnt_r == $past(quiet_cnt_r))
    else $error("automatic test not scheduled");
  start_next_a: assert property (@(posedge clk) disable iff (!rst_n)
    cycle_start && pending_r && !self_test_active |=> self_test_active ##0 step_r == self_test_pkg::ST_CMP_WIN)
    else $error("pending test did not start");
  zebra_fail_a: assert property (@(posedge clk) disable iff (!rst_n)
    step_strobe && step_r == self_test_pkg::ST_ZEBRA_A && adc_code != self_test_pkg::ZEBRA_CODE
    |=> fail_r)
    else $error("bad zebra code not flagged");

endmodule : cell_monitor_self_test_seq

// [mcu_model.sv]
`timescale 1ns/1ps

// Outside controller on the open-collector request line
module mcu_model (
  input  wire logic clk,
  output logic      pull_low  // High while the controller sinks the line
);
  // Line is released to the pull-up until a request is made
  initial pull_low = 1'b0;

  // Sink the line for n clocks, then let the pull-up take it back
  task automatic request(input int unsigned n);
    @(negedge clk);
    pull_low = 1'b1;
    repeat (n) @(negedge clk);
    pull_low = 1'b0;
  endtask : request
endmodule : mcu_model

// [self_test_pkg.sv]
package self_test_pkg;

  // Measurement cycles without an outside request before an automatic self test
  localparam int unsigned AUTO_TEST_CYCLES   = 1024;
  // Width of the automatic test counter
  localparam int unsigned AUTO_CNT_W         = 11;
  // Number of cell channels the multiplexer may visit
  localparam int unsigned MAX_CHANNELS       = 14;
  // Reference tolerance in percent around nominal
  localparam int unsigned REF_TOL_PCT        = 5;
  // Width of the digitised reference and ADC output codes
  localparam int unsigned CODE_W             = 12;
  // Nominal digitised reference code
  localparam logic [11:0] REF_NOMINAL_CODE   = 12'hC00;
  // First decimation filter test pattern; the second is its complement
  localparam logic [11:0] ZEBRA_CODE         = 12'hAAA;
  // Index of the lowest cell channel and of the highest that self test checks for opens
  localparam int unsigned OPEN_CHECK_LO      = 0;
  localparam int unsigned OPEN_CHECK_HI      = 10;
  // Reset level of the pass output
  localparam logic        PASS_RESET         = 1'b1;

  // Self test steps, one-hot
  typedef enum logic [6:0] {
    ST_IDLE    = 7'h01,
    ST_CMP_WIN = 7'h02,
    ST_CMP_UP  = 7'h04,
    ST_CMP_LO  = 7'h08,
    ST_ZEBRA_A = 7'h10,
    ST_ZEBRA_B = 7'h20,
    ST_DONE    = 7'h40
  } step_e;

endpackage : self_test_pkg

// [status_clock_gate.sv]
`timescale 1ns/1ps

// Status clock gate: arms or disarms the status clock only at cycle ends
module status_clock_gate (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic cycle_done,     // One-cycle pulse at the end of a measurement cycle
  input  wire logic all_ok,         // Stack healthy, chain matching, cells in window
  input  wire logic enable_clock_in,
  output logic      status_clock_out,
  output logic      status_clock_out_n
);

  logic armed_r; // Decision latched at the last cycle end

  // Decision is taken only at the end of a cycle, never part way
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_r <= 1'b0;
    end else if (cycle_done) begin
      armed_r <= all_ok;
    end
  end

  // Follows the enable clock in phase when armed, else true low and complement high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_clock_out   <= 1'b0;
      status_clock_out_n <= 1'b1;
    end else begin
      status_clock_out   <= armed_r & enable_clock_in;
      status_clock_out_n <= ~(armed_r & enable_clock_in);
    end
  end

  gate_on_cycle_a: assert property (@(posedge clk) disable iff (!rst_n)
    !cycle_done |=> armed_r == $past(armed_r))
    else $error("status clock decision changed mid cycle");

endmodule : status_clock_gate

// [testbench.sv]
`timescale 1ns/1ps

// Bench standing in for the measurement sequencer and analog path
module testbench;
  logic        clk         = 1'b0;     // 40 MHz
  logic        reset_n     = 1'b0;
  logic        cycle_start = 1'b0;
  logic        cycle_done  = 1'b0;
  logic        chan_strobe = 1'b0;
  logic [3:0]  chan_index  = 4'h0;
  logic        chain_match = 1'b1;
  logic        cell_fault  = 1'b0;     // Any cell or temperature fault
  logic        ecin        = 1'b0;     // Enable clock
  logic        step_strobe = 1'b0;
  logic [11:0] ref_c       = 12'hC00;  // Reference code fed during test
  logic [11:0] za          = 12'hAAA;  // First waveform result
  logic [11:0] zb          = 12'h555;  // Second waveform result
  logic [13:0] open_w      = 14'h0000;
  logic        dc_raw      = 1'b0;
  logic        dc_float    = 1'b1;     // Config pin left open
  logic        pull_low;               // Controller sinks line
  logic        req_line;               // Resolved request wire
  logic        st_out, st_oe, pass, active, uv_en, zsel, dcs, sco, sco_n;
  logic [1:0]  tmode;
  int          miscompares  = 0;
  int          total_checks = 0;

  // Pull-up wins unless some party sinks the wire
  assign req_line = ~(pull_low | (st_oe & ~st_out));

  always #12.5 clk = ~clk;

  // Enable clock, slow against clk, changed on the drive edge
  always begin
    repeat (4) @(negedge clk);
    ecin = ~ecin;
  end

  mcu_model i_mcu (.clk(clk), .pull_low(pull_low));

  cell_monitor_self_test_seq i_dut (
    .clk(clk), .reset_n(reset_n), .cycle_start(cycle_start), .cycle_done(cycle_done),
    .chan_strobe(chan_strobe), .chan_index(chan_index), .chan_requested(14'h0003),
    .cell_fault(cell_fault), .chain_match(chain_match), .enable_clock_in(ecin),
    .enabled(1'b1), .step_strobe(step_strobe),
    .cmp_above_lower(tmode !== 2'h2), .cmp_below_upper(tmode !== 2'h1),
    .ref_code(ref_c), .adc_code(zsel ? zb : za), .open_wire_ov(open_w),
    .duty_cycle_select_raw(dc_raw), .duty_cycle_select_float(dc_float),
    .self_test_request_n_in(req_line), .self_test_request_n_out(st_out),
    .self_test_request_n_oe(st_oe), .self_test_pass(pass), .self_test_active(active),
    .uv_check_enable(uv_en), .threshold_mode(tmode), .zebra_select(zsel),
    .duty_cycle_select(dcs), .status_clock_out(sco), .status_clock_out_n(sco_n)
  );

  // Compare and count; four-state so unknowns never match
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  // One measurement cycle; skip leaves channel 1 unconverted
  task automatic cyc(input logic test, input logic skip);
    @(negedge clk);
    cycle_start = 1'b1;
    @(negedge clk);
    cycle_start = 1'b0;
    chan_strobe = 1'b1;
    chan_index  = 4'h0;
    @(negedge clk);
    chan_index  = 4'h1;
    chan_strobe = !skip;
    @(negedge clk);
    chan_strobe = 1'b0;
    chk(active, test);
    chk(st_oe, test);
    chk(st_out, 1'b0);
    chk(uv_en, !test);
    // Step through the five analog checks in order
    if (test) begin
      for (int k = 0; k < 5; k++) begin
        if (k < 3) chk(tmode, k);
        chk(zsel, k == 4);
        step_strobe = 1'b1;
        @(negedge clk);
        step_strobe = 1'b0;
        @(negedge clk);
      end
    end
    cycle_done = 1'b1;
    @(negedge clk);
    cycle_done = 1'b0;
    @(negedge clk);
    chk(st_oe, 1'b0);
  endtask : cyc

  // Request a test with the given analog results, then restore good ones
  task automatic test_run(input logic [11:0] rc, input logic [11:0] b,
                          input logic [13:0] ow, input logic exp);
    ref_c  = rc;
    zb     = b;
    open_w = ow;
    i_mcu.request(2);
    repeat (4) @(negedge clk);  // Two sync stages plus edge detect
    cyc(1'b1, 1'b0);
    chk(pass, exp);
    ref_c  = 12'hC00;
    zb     = 12'h555;
    open_w = 14'h0000;
  endtask : test_run

  // Test cut short by an early cycle end: pass must keep its last value
  task automatic cut_run(input logic exp);
    i_mcu.request(2);
    repeat (4) @(negedge clk);
    cycle_start = 1'b1;
    @(negedge clk);
    cycle_start = 1'b0;
    chan_strobe = 1'b1;
    chan_index  = 4'h0;
    @(negedge clk);
    chan_index  = 4'h1;
    @(negedge clk);
    chan_strobe = 1'b0;
    chk(active, 1'b1);
    cycle_done  = 1'b1;
    @(negedge clk);
    cycle_done  = 1'b0;
    @(negedge clk);
    chk(st_oe, 1'b0);
    chk(pass, exp);
  endtask : cut_run

  // Count status clock changes over n clocks
  task automatic toggles(input int n, output int t);
    logic prev;
    t    = 0;
    prev = sco;
    repeat (n) begin
      @(negedge clk);
      if (sco !== prev) t++;
      prev = sco;
    end
  endtask : toggles

  // Main sequence
  initial begin
    int t;
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    chk(pass, 1'b1);
    chk(st_oe, 1'b0);
    chk(sco, 1'b0);
    chk(sco_n, 1'b1);
    chk(dcs, 1'b1);
    cyc(1'b0, 1'b0);
    toggles(24, t);
    chk(t > 0, 1'b1);
    // Two requests before the test starts give one test only
    i_mcu.request(2);
    repeat (2) @(negedge clk);
    test_run(12'hC00, 12'h555, 14'h0000, 1'b1);
    cyc(1'b0, 1'b0);
    test_run(12'hC00, 12'h554, 14'h0000, 1'b0);
    toggles(24, t);
    chk(t > 0, 1'b1);
    cut_run(1'b0);
    test_run(12'hC00, 12'h555, 14'h0000, 1'b1);
    // Reference band edges: 153 codes off passes, 154 fails
    test_run(12'hC99, 12'h555, 14'h0000, 1'b1);
    test_run(12'hC9A, 12'h555, 14'h0000, 1'b0);
    test_run(12'hB67, 12'h555, 14'h0000, 1'b1);
    test_run(12'hFFF, 12'h555, 14'h0000, 1'b0);
    test_run(12'hC00, 12'h555, 14'h0800, 1'b1);
    test_run(12'hC00, 12'h555, 14'h0400, 1'b0);
    test_run(12'hC00, 12'h555, 14'h0001, 1'b0);
    cyc(1'b0, 1'b1);
    test_run(12'hC00, 12'h555, 14'h0000, 1'b0);
    test_run(12'hC00, 12'h555, 14'h0000, 1'b1);
    // Chain break mid-cycle: clock keeps going until the cycle ends
    chain_match = 1'b0;
    toggles(24, t);
    chk(t > 0, 1'b1);
    cyc(1'b0, 1'b0);
    toggles(24, t);
    chk(t != 0, 1'b0);
    chk(sco_n, 1'b1);
    chain_match = 1'b1;
    // Cell fault alone, chain restored, must keep the status clock stopped at the next cycle end
    cell_fault  = 1'b1;
    cyc(1'b0, 1'b0);
    toggles(24, t);
    chk(t != 0, 1'b0);
    cell_fault  = 1'b0;
    dc_float    = 1'b0;
    @(negedge clk);
    chk(dcs, dc_raw);
    // Quiet run until the automatic test: the chain-break and fault cycles
    // are the first two of the 1024 quiet cycles
    repeat (1022) cyc(1'b0, 1'b0);
    cyc(1'b1, 1'b0);
    chk(pass, 1'b1);
    final_report();
  end

  // Hang guard
  initial begin
    #1ms;
    miscompares++;
    final_report();
  end
endmodule : testbench
